/* hw/ofs_selector.sv */
// module: output function selector with avalon-mm code registers
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

// What this block does
// - code zero marks the terminal unused and drives no function onto it
// - codes 1 to 127 echo the input signal of the same number
// - code 128 holds the terminal off at all times
// - code 129 drives high while an alarm is present
// - code 130 drives low while an alarm is present, high otherwise
// - code 131 drives high once system preparation completes after power up
// - code 132 drives high while the driver is ready to operate
// - code 134 drives high while the motor is moving
// - code 135 drives high while any information condition is present
// - code 136 drives high during internal processing
// - code 138 drives high when positioning is complete, never in cyclic sync mode
// - code 140 drives high while torque sits at its upper limit
// - code 141 drives high at target speed, never in cyclic sync mode
// - codes 142 and 143 show winding excitation and automatic current cutback
// - codes 144 and 145 show homing done and coordinate established
// - codes 160 to 162 drive high while inside the matching zone
// - code 149 drives high when another position preset is needed
// - codes 150 and 151 show mechanical and factory origin set
// - code 152 toggles per wrap overflow; 156 shows wrap origin when wrapping enabled
// - codes 153 and 154 show forward and reverse software limit reached
// - code 155 pulses at each full revolution from the preset position
// - code 157 pulses at each fixed step angle of the command position
module ofs_selector (
    input wire logic clock,
    input wire logic arst_n,
    input wire ofs_pkg::ofs_bus_req_type bus_req,
    output ofs_pkg::ofs_bus_rsp_type bus_rsp,
    input wire logic [ofs_pkg::OFS_INPUTS-1:0] input_levels,
    input wire ofs_pkg::ofs_status_type status,
    output logic [ofs_pkg::OFS_TERMINALS-1:0] terminal_level,
    output logic [ofs_pkg::OFS_TERMINALS-1:0] terminal_used
);
    import ofs_pkg::*;

    // ***************************************
    // state
    // ***************************************
    typedef struct packed {
        logic [OFS_TERMINALS-1:0][7:0] code;
        logic [OFS_TERMINALS-1:0] level;
        logic [OFS_TERMINALS-1:0] used;
        logic wrap_toggle;
        logic ack;
        logic [31:0] readdata;
    } ofs_state_type;

    ofs_state_type state;
    ofs_state_type next_state;
    logic [1:0] rst_sync;
    logic rst_n;
    logic request;

    // ***************************************
    // reset release
    // ***************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];
    assign request = bus_req.read | bus_req.write;

    // ***************************************
    // bus answer
    // ***************************************
    assign bus_rsp.waitrequest = request & ~state.ack;
    assign bus_rsp.readdata = state.readdata;
    assign terminal_level = state.level;
    assign terminal_used = state.used;

    // ***************************************
    // next state
    // ***************************************
    always_comb begin
        logic [7:0] c;
        logic lvl;
        logic [5:0] slot_addr;
        c = 8'h00;
        lvl = 1'b0;
        slot_addr = 6'h00;
        next_state = state;

        // one wait state, then the answer
        next_state.ack = request & ~state.ack;
        if (request && !state.ack) begin
            next_state.readdata = 32'h0000_0000;
            if (bus_req.read) begin
                for (int i = 0; i < OFS_TERMINALS; i++) begin
                    slot_addr = REG_CODE_BASE + 6'(i * 4);
                    if (bus_req.address == slot_addr) begin
                        next_state.readdata = {24'h00_0000, state.code[i]};
                    end
                end
                if (bus_req.address == REG_LEVELS) begin
                    next_state.readdata = {24'h00_0000, state.level};
                end
                if (bus_req.address == REG_USED) begin
                    next_state.readdata = {24'h00_0000, state.used};
                end
            end
        end
        if (bus_req.write && state.ack && bus_req.byteenable[0]) begin
            for (int i = 0; i < OFS_TERMINALS; i++) begin
                slot_addr = REG_CODE_BASE + 6'(i * 4);
                if (bus_req.address == slot_addr) begin
                    next_state.code[i] = bus_req.writedata[7:0];
                end
            end
        end

        if (status.wrap_exceeded) begin
            next_state.wrap_toggle = ~state.wrap_toggle;
        end

        for (int i = 0; i < OFS_TERMINALS; i++) begin
            c = state.code[i];
            lvl = 1'b0;
            if (c != CODE_UNUSED && c <= CODE_ECHO_LAST) begin
                lvl = input_levels[c[6:0]];
            end else begin
                case (c)
                    CODE_UNUSED: lvl = 1'b0;
                    CODE_CONST_OFF: lvl = 1'b0;
                    CODE_ALARM_HIGH: lvl = status.alarm;
                    CODE_ALARM_LOW: lvl = ~status.alarm;
                    CODE_SYS_PREPARED: lvl = status.system_prepared;
                    CODE_READY: lvl = status.ready;
                    CODE_MOVING: lvl = status.moving;
                    CODE_INFO: lvl = status.info_present;
                    CODE_PROCESSING: lvl = status.internal_processing;
                    CODE_IN_POSITION: begin
                        lvl = status.in_position & ~status.cyclic_sync_position_mode;
                    end
                    CODE_TORQUE_LIMIT: lvl = status.torque_at_limit;
                    CODE_SPEED_REACHED: begin
                        lvl = status.target_speed_reached
                            & ~status.cyclic_sync_position_mode;
                    end
                    CODE_EXCITED: lvl = status.windings_excited;
                    CODE_CUTBACK: lvl = status.current_cutback_active;
                    CODE_HOME_DONE: lvl = status.home_done;
                    CODE_COORD_SET: lvl = status.coordinate_established;
                    CODE_PRESET_AGAIN: lvl = status.preset_needed_again;
                    CODE_MECH_ORIGIN: lvl = status.mech_origin_set;
                    CODE_FACTORY_ORIGIN: lvl = status.factory_origin_set;
                    CODE_WRAP_TOGGLE: lvl = next_state.wrap_toggle;
                    CODE_FWD_LIMIT: lvl = status.fwd_soft_limit_hit;
                    CODE_REV_LIMIT: lvl = status.rev_soft_limit_hit;
                    CODE_REV_PULSE: lvl = status.revolution_done;
                    CODE_WRAP_ORIGIN: begin
                        lvl = status.at_wrap_origin & status.wrap_enabled;
                    end
                    CODE_STEP_PULSE: lvl = status.step_angle_done;
                    CODE_ZONE0: lvl = status.zone_inside[0];
                    CODE_ZONE1: lvl = status.zone_inside[1];
                    CODE_ZONE2: lvl = status.zone_inside[2];
                    default: lvl = 1'b0;
                endcase
            end
            next_state.level[i] = lvl;
            next_state.used[i] = (c != CODE_UNUSED);
        end
    end

    // ***************************************
    // registers
    // ***************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule

/* hw/ofs_pkg.sv */
// package: codes, register map and carrier types of the output function selector
package ofs_pkg;

    localparam int OFS_TERMINALS = 8;
    localparam int OFS_INPUTS = 128;

    // ***************************************
    // assignment codes
    // ***************************************
    localparam logic [7:0] CODE_UNUSED = 8'h00;
    localparam logic [7:0] CODE_ECHO_LAST = 8'h7F;
    localparam logic [7:0] CODE_CONST_OFF = 8'h80;
    localparam logic [7:0] CODE_ALARM_HIGH = 8'h81;
    localparam logic [7:0] CODE_ALARM_LOW = 8'h82;
    localparam logic [7:0] CODE_SYS_PREPARED = 8'h83;
    localparam logic [7:0] CODE_READY = 8'h84;
    localparam logic [7:0] CODE_MOVING = 8'h86;
    localparam logic [7:0] CODE_INFO = 8'h87;
    localparam logic [7:0] CODE_PROCESSING = 8'h88;
    localparam logic [7:0] CODE_IN_POSITION = 8'h8A;
    localparam logic [7:0] CODE_TORQUE_LIMIT = 8'h8C;
    localparam logic [7:0] CODE_SPEED_REACHED = 8'h8D;
    localparam logic [7:0] CODE_EXCITED = 8'h8E;
    localparam logic [7:0] CODE_CUTBACK = 8'h8F;
    localparam logic [7:0] CODE_HOME_DONE = 8'h90;
    localparam logic [7:0] CODE_COORD_SET = 8'h91;
    localparam logic [7:0] CODE_PRESET_AGAIN = 8'h95;
    localparam logic [7:0] CODE_MECH_ORIGIN = 8'h96;
    localparam logic [7:0] CODE_FACTORY_ORIGIN = 8'h97;
    localparam logic [7:0] CODE_WRAP_TOGGLE = 8'h98;
    localparam logic [7:0] CODE_FWD_LIMIT = 8'h99;
    localparam logic [7:0] CODE_REV_LIMIT = 8'h9A;
    localparam logic [7:0] CODE_REV_PULSE = 8'h9B;
    localparam logic [7:0] CODE_WRAP_ORIGIN = 8'h9C;
    localparam logic [7:0] CODE_STEP_PULSE = 8'h9D;
    localparam logic [7:0] CODE_ZONE0 = 8'hA0;
    localparam logic [7:0] CODE_ZONE1 = 8'hA1;
    localparam logic [7:0] CODE_ZONE2 = 8'hA2;

    // ***************************************
    // register map (byte addresses)
    // ***************************************
    localparam int OFS_ADDR_W = 6;
    localparam logic [5:0] REG_CODE_BASE = 6'h00;
    localparam logic [5:0] REG_LEVELS = 6'h20;
    localparam logic [5:0] REG_USED = 6'h24;
    localparam logic [7:0] CODE_RESET = 8'h00;

    // ***************************************
    // carrier types
    // ***************************************
    typedef struct packed {
        logic alarm;
        logic system_prepared;
        logic ready;
        logic moving;
        logic info_present;
        logic internal_processing;
        logic in_position;
        logic torque_at_limit;
        logic target_speed_reached;
        logic windings_excited;
        logic current_cutback_active;
        logic home_done;
        logic coordinate_established;
        logic preset_needed_again;
        logic mech_origin_set;
        logic factory_origin_set;
        logic wrap_exceeded;
        logic wrap_enabled;
        logic at_wrap_origin;
        logic fwd_soft_limit_hit;
        logic rev_soft_limit_hit;
        logic revolution_done;
        logic step_angle_done;
        logic [2:0] zone_inside;
        logic cyclic_sync_position_mode;
    } ofs_status_type;

    typedef struct packed {
        logic [OFS_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } ofs_bus_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } ofs_bus_rsp_type;

endpackage

/* verif/ofs_plc.sv */
// partner: controller that latches the terminal levels and used flags every clock, marked valid on request
`timescale 1ns/1ps
module ofs_plc (
    input wire logic clock,
    input wire logic sample,
    input wire logic [7:0] terminal_level,
    input wire logic [7:0] terminal_used,
    output logic [15:0] obs,
    output logic obs_valid
);
    always_ff @(posedge clock) begin
        obs <= {terminal_used, terminal_level};
        obs_valid <= sample;
    end
endmodule

/* verif/ofs_selector_chk.sv */
// checker: properties on the selector ports, terminal 0 shadowed
`timescale 1ns/1ps
module ofs_chk (
    input wire logic clock,
    input wire logic arst_n,
    input wire ofs_pkg::ofs_bus_req_type bus_req,
    input wire ofs_pkg::ofs_bus_rsp_type bus_rsp,
    input wire logic [ofs_pkg::OFS_INPUTS-1:0] input_levels,
    input wire ofs_pkg::ofs_status_type status,
    input wire logic [ofs_pkg::OFS_TERMINALS-1:0] terminal_level,
    input wire logic [ofs_pkg::OFS_TERMINALS-1:0] terminal_used
);
    import ofs_pkg::*;
    logic [7:0] c0;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            c0 <= 8'h00;
        end else if (bus_req.write && !bus_rsp.waitrequest && bus_req.byteenable[0] &&
                     bus_req.address == REG_CODE_BASE) begin
            c0 <= bus_req.writedata[7:0];
        end
    end
    wait_state_a:
    assert property (bus_rsp.waitrequest |=> !bus_rsp.waitrequest) else $error("no answer");
    unused_off_a:
    assert property (c0 == 8'h00 |=> !terminal_level[0] && !terminal_used[0])
        else $error("unused driven");
    input_echo_a:
    assert property (c0 inside {[8'h01:8'h7F]} |=> terminal_level[0] == $past(input_levels[c0]))
        else $error("echo wrong");
    const_off_a:
    assert property (c0 == 8'h80 |=> !terminal_level[0]) else $error("const not off");
    alarm_high_a:
    assert property (c0 == 8'h81 |=> terminal_level[0] == $past(status.alarm))
        else $error("alarm wrong");
    alarm_low_a:
    assert property (c0 == 8'h82 |=> terminal_level[0] != $past(status.alarm))
        else $error("alarm low wrong");
    in_pos_sync_a:
    assert property (c0 == 8'h8A && status.cyclic_sync_position_mode |=> !terminal_level[0])
        else $error("in position in sync mode");
    wrap_origin_a:
    assert property (c0 == 8'h9C && !status.wrap_enabled |=> !terminal_level[0])
        else $error("wrap origin wrong");
    unlisted_off_a:
    assert property (c0 > 8'hA2 |=> !terminal_level[0]) else $error("unlisted on");
endmodule
bind ofs_selector ofs_chk ofs_chk_inst (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .input_levels(input_levels), .status(status),
    .terminal_level(terminal_level), .terminal_used(terminal_used));

/* verif/ofs_selector_tb.sv */
// testbench: writes codes, drives status, compares terminals and registers
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ofs_selector_tb;
    import ofs_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    ofs_bus_req_type bus_req = '0;
    ofs_bus_rsp_type bus_rsp;
    logic [127:0] input_levels = '0;
    ofs_status_type status = '0;
    ofs_status_type st;
    logic [7:0] terminal_level, terminal_used, e, used;
    logic [15:0] obs;
    logic [31:0] exp_word;
    logic sample = 1'b0, obs_valid, rd_valid = 1'b0, tog = 1'b0;
    logic [31:0] rd_data = '0;
    logic [31:0] exp_q[$];
    logic [7:0] codes[8];
    int mismatches = 0, total_checks = 0, seed = 86280;
    ofs_selector ofs_selector_inst (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
        .bus_rsp(bus_rsp), .input_levels(input_levels), .status(status),
        .terminal_level(terminal_level), .terminal_used(terminal_used));
    ofs_plc ofs_plc_inst (.clock(clock), .sample(sample), .terminal_level(terminal_level),
        .terminal_used(terminal_used), .obs(obs), .obs_valid(obs_valid));
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        logic ok;
        ok = 1'b0;
        bus_req <= '{a, !wr, wr, be, d};
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clock);
            ok = (bus_rsp.waitrequest === 1'b0);
        end
        if (!ok) begin
            mismatches++;
            give_verdict();
        end
        rd_data <= bus_rsp.readdata;
        bus_req <= '0;
        rd_valid <= !wr;
        @(posedge clock);
        rd_valid <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    function automatic logic fx(input logic [7:0] c);
        case (c) inside
            [8'h01:8'h7F]: return input_levels[c];
            8'h81: return status.alarm;
            8'h82: return !status.alarm;
            8'h83: return status.system_prepared;
            8'h84: return status.ready;
            8'h86: return status.moving;
            8'h87: return status.info_present;
            8'h88: return status.internal_processing;
            8'h8A: return status.in_position && !status.cyclic_sync_position_mode;
            8'h8C: return status.torque_at_limit;
            8'h8D: return status.target_speed_reached && !status.cyclic_sync_position_mode;
            8'h8E: return status.windings_excited;
            8'h8F: return status.current_cutback_active;
            8'h90: return status.home_done;
            8'h91: return status.coordinate_established;
            8'h95: return status.preset_needed_again;
            8'h96: return status.mech_origin_set;
            8'h97: return status.factory_origin_set;
            8'h98: return tog;
            8'h99: return status.fwd_soft_limit_hit;
            8'h9A: return status.rev_soft_limit_hit;
            8'h9B: return status.revolution_done;
            8'h9C: return status.at_wrap_origin && status.wrap_enabled;
            8'h9D: return status.step_angle_done;
            [8'hA0:8'hA2]: return status.zone_inside[c[1:0]];
            default: return 1'b0;
        endcase
    endfunction
    task automatic probe();
        repeat (2) @(posedge clock);
        for (int t = 0; t < 8; t++) begin
            e[t] = fx(codes[t]);
            used[t] = codes[t] != 8'h00;
        end
        exp_q.push_back({16'h0, used, e});
        sample <= 1'b1;
        @(posedge clock);
        sample <= 1'b0;
        rd(REG_USED, {24'h0, used});
        rd(REG_LEVELS, {24'h0, e});
    endtask
    always @(posedge clock) begin
        if (obs_valid || rd_valid) begin
            exp_word = exp_q.pop_front();
            `CHK(obs_valid ? {16'h0, obs} : rd_data, exp_word)
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd(6'h04, {24'h0, CODE_RESET});
        for (int c = 0; c < 256; c++) begin
            for (int t = 0; t < 8; t++) begin
                codes[t] = 8'(c + t * 37);
                bus(1'b1, 6'(4 * t), {24'($random(seed)), codes[t]}, 4'h1);
            end
            st = ofs_status_type'(27'($random(seed)));
            st.wrap_exceeded = 1'b0;
            status <= st;
            input_levels <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            probe();
            rd(6'(4 * (c % 8)), {24'h0, codes[c % 8]});
        end
        bus(1'b1, 6'h00, 32'h98, 4'h0);
        rd(6'h00, {24'h0, codes[0]});
        bus(1'b1, 6'h3C, 32'h81, 4'hF);
        rd(6'h3C, 32'h0);
        codes[0] = 8'h98;
        bus(1'b1, 6'h00, 32'h98, 4'h1);
        for (int k = 0; k < 2; k++) begin
            status.wrap_exceeded <= 1'b1;
            @(posedge clock);
            status.wrap_exceeded <= 1'b0;
            tog = !tog;
            probe();
        end
        repeat (4) @(posedge clock);
        if (exp_q.size() != 0) begin
            mismatches++;
        end
        give_verdict();
    end
endmodule
